// >>> omsc_board.sv
// board strap model for the mode pins
// assumes the bench moves the strap only while reset is held
`timescale 1ns/1ns
`default_nettype none
module omsc_board (
    input wire logic clk, // system clock
    input wire logic rstn, // reset, active low
    input wire logic [2:0] strap, // wanted mode, never zero
    output logic [2:0] levels // strap pin levels
);
    // straps only follow under reset, so the device never sees them move while running
    always_ff @(posedge clk) begin
        if (!rstn) begin
            levels <= strap;
        end
    end
endmodule
`default_nettype wire

// >>> omsc_ctrl.sv
// operating mode decode and system control registers
// assumes an apb master on CLK and the cpu, bus and port logic nearby

`timescale 1ns/1ns
`default_nettype none

module omsc_ctrl #(
    parameter int WAIT_BASE = omsc_pkg::WAIT_BASE_STATES // shortest doubling wait
) (
    input wire logic CLK, // system clock, 250 MHz
    input wire logic RSTN, // sync reset, active low
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb direction
    input wire logic [omsc_pkg::ADDR_W-1:0] PADDR, // apb byte address
    input wire logic [omsc_pkg::DATA_W-1:0] PWDATA, // apb write data
    input wire logic [3:0] PSTRB, // apb byte strobes
    output logic PREADY, // apb ready
    output logic [omsc_pkg::DATA_W-1:0] PRDATA, // apb read data
    output logic PSLVERR, // apb error, unmapped
    input wire logic [2:0] MODE_PIN_LEVELS, // strap pins
    input wire logic NMI_PIN, // nonmaskable interrupt pin
    input wire logic [omsc_pkg::AREA_N-1:0] AREA_WIDTH_CONTROL, // 1 = 16-bit area
    input wire logic [omsc_pkg::UPPER_W-1:0] BUS_RELEASE_CONTROL, // its bits 7 to 5
    input wire logic [omsc_pkg::P1_W-1:0] PORT1_DIRECTION, // port 1 ddr
    input wire logic [omsc_pkg::P2_W-1:0] PORT2_DIRECTION, // port 2 ddr
    input wire logic [omsc_pkg::P5_W-1:0] PORT5_DIRECTION, // port 5 ddr
    input wire logic SLEEP_EXEC, // cpu runs the sleep instruction
    input wire logic WAKE_IRQ, // interrupt that ends sleep
    input wire logic EXT_IRQ, // external interrupt that ends standby
    input wire logic EXC_ENTRY, // interrupt or trap entry
    input wire logic RAM_ADDR_HIT, // access falls on on-chip ram
    output logic MODE_RESERVED, // strap code zero
    output logic EXPANDED, // external bus in use
    output logic ROM_ENABLE, // on-chip rom reachable
    output logic SPACE_16M, // 16-mbyte space
    output logic BUS_INIT16, // reset width of the area control
    output logic BUS16, // external bus now 16 bits
    output logic [omsc_pkg::P1_W-1:0] P1_ADDR_OUT, // pins as a7..a0
    output logic [omsc_pkg::P2_W-1:0] P2_ADDR_OUT, // pins as a15..a8
    output logic [omsc_pkg::P5_W-1:0] P5_ADDR_OUT, // pins as a19..a16
    output logic A20_ADDR_OUT, // pin as a20
    output logic [omsc_pkg::UPPER_W-1:0] UPPER_ADDR_OUT, // pins as a23..a21
    output logic RAM_ENABLE, // on-chip ram on
    output logic RAM_ROUTE_EXT, // ram address goes external
    output logic SLEEP_ACTIVE, // in sleep
    output logic STANDBY_ACTIVE, // in software standby
    output logic SETTLING, // oscillator settling wait
    output logic UI_IS_MASK, // secondary flag is a mask
    output logic SET_I_FLAG, // pulse: set interrupt mask
    output logic SET_UI_FLAG, // pulse: set secondary flag
    output logic NMI_REQUEST // pulse: nmi edge seen
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pins_s; // mode pins and nmi, synchronised
    wire [2:0] mode_levels = pins_s[2:0]; // mode_pin_levels
    wire nmi_s = pins_s[3]; // nmi level

    omsc_sync #(.W(4)) i_omsc_sync (
        .clk(CLK),
        .rstn(RSTN),
        .d({NMI_PIN, MODE_PIN_LEVELS}),
        .q(pins_s)
    );

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    omsc_pkg::omsc_mode_cfg_t cfg_q; // registered mode table
    wire omsc_pkg::omsc_mode_cfg_t cfg_d = omsc_pkg::omsc_decode(mode_levels);

    // straps are held constant, so one register stage is enough
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup = PSEL && !PENABLE; // first cycle of a transfer
    wire hit_rb = (PADDR == omsc_pkg::ADDR_MODE_READBACK);
    wire hit_sc = (PADDR == omsc_pkg::ADDR_SYSTEM_CONTROL);
    wire wr_fire = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    wire sc_wr = wr_fire && hit_sc && PSTRB[0]; // lane 0 holds the register

    logic pready_q; // access phase ready
    logic [7:0] rdata_q; // read data, low byte
    logic slverr_q; // unmapped address
    omsc_pkg::omsc_sysctl_t sc_q; // system_control fields

    wire [7:0] sc_image = {sc_q.software_standby_select, sc_q.sts, sc_q.ue, sc_q.nonmaskable_edge_select, 1'b0, sc_q.onchip_ram_enable}
        | omsc_pkg::SYSCTL_ONES;
    wire [7:0] rb_image = omsc_pkg::RB_ONES | {5'h00, mode_levels};
    wire [7:0] rd_mux = hit_rb ? rb_image : (hit_sc ? sc_image : 8'h00);

    // no wait state: data is latched in setup, ready in the first access cycle
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pready_q <= 1'b0;
            slverr_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            pready_q <= setup;
            slverr_q <= setup && !hit_rb && !hit_sc;
            if (setup && !PWRITE) begin
                rdata_q <= rd_mux; // pin levels caught at the read setup
            end
        end
    end

    // ------------------------------------------------------------
    // system control register
    // ------------------------------------------------------------
    wire omsc_pkg::omsc_sysctl_t sc_rst = '{
        software_standby_select: omsc_pkg::SYSCTL_RESET[omsc_pkg::SOFTWARE_STANDBY_SELECT_BIT],
        sts: omsc_pkg::SYSCTL_RESET[omsc_pkg::STS_HI:omsc_pkg::STS_LO],
        ue: omsc_pkg::SYSCTL_RESET[omsc_pkg::UE_BIT],
        nonmaskable_edge_select: omsc_pkg::SYSCTL_RESET[omsc_pkg::NONMASKABLE_EDGE_SELECT_BIT],
        onchip_ram_enable: omsc_pkg::SYSCTL_RESET[omsc_pkg::ONCHIP_RAM_ENABLE_BIT]};

    // writes to the readback fall through: nothing stores them
    // standby never touches this register, so ram enable survives it
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            sc_q <= sc_rst;
        end else if (sc_wr) begin
            sc_q.software_standby_select <= PWDATA[omsc_pkg::SOFTWARE_STANDBY_SELECT_BIT];
            sc_q.sts <= PWDATA[omsc_pkg::STS_HI:omsc_pkg::STS_LO];
            sc_q.ue <= PWDATA[omsc_pkg::UE_BIT];
            sc_q.nonmaskable_edge_select <= PWDATA[omsc_pkg::NONMASKABLE_EDGE_SELECT_BIT];
            sc_q.onchip_ram_enable <= PWDATA[omsc_pkg::ONCHIP_RAM_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------
    omsc_pkg::omsc_pwr_t pwr_q; // current power state
    omsc_pkg::omsc_pwr_t pwr_d; // next power state
    logic [omsc_pkg::CNT_W-1:0] wait_q; // settling count left
    logic [omsc_pkg::CNT_W-1:0] wait_d;

    // illegal codes 11x fall back to the base wait, the shortest doubling wait
    wire [omsc_pkg::CNT_W-1:0] wait_base = omsc_pkg::CNT_W'(WAIT_BASE);
    wire sts_short = (sc_q.sts == omsc_pkg::STS_SHORT);
    wire sts_doubling = (sc_q.sts <= omsc_pkg::STS_LONGEST);
    wire [omsc_pkg::CNT_W-1:0] wait_cycles = sts_short ? omsc_pkg::WAIT_SHORT_STATES
        : (sts_doubling ? (wait_base << sc_q.sts) : wait_base);

    always_comb begin
        pwr_d = pwr_q;
        wait_d = wait_q;
        unique case (pwr_q)
            omsc_pkg::PWR_RUN: begin
                if (SLEEP_EXEC) begin
                    // standby select decides where sleep goes
                    pwr_d = sc_q.software_standby_select ? omsc_pkg::PWR_STANDBY : omsc_pkg::PWR_SLEEP;
                end
            end
            omsc_pkg::PWR_SLEEP: begin
                if (WAKE_IRQ) begin
                    pwr_d = omsc_pkg::PWR_RUN;
                end
            end
            omsc_pkg::PWR_STANDBY: begin
                if (EXT_IRQ) begin
                    // standby select is left at one on this exit
                    pwr_d = omsc_pkg::PWR_SETTLE;
                    wait_d = wait_cycles - 18'h00001;
                end
            end
            omsc_pkg::PWR_SETTLE: begin
                if (wait_q == '0) begin
                    pwr_d = omsc_pkg::PWR_RUN;
                end else begin
                    wait_d = wait_q - 18'h00001;
                end
            end
            default: begin
                pwr_d = omsc_pkg::PWR_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            pwr_q <= omsc_pkg::PWR_RUN;
            wait_q <= '0;
        end else begin
            pwr_q <= pwr_d;
            wait_q <= wait_d;
        end
    end

    // ------------------------------------------------------------
    // nmi edge detect
    // ------------------------------------------------------------
    logic nmi_prev_q; // last synchronised level
    logic [1:0] arm_q; // hides the reset-time edge of the sync chain
    wire nmi_armed = (arm_q == omsc_pkg::NMI_ARM_CYCLES);
    wire nmi_edge = sc_q.nonmaskable_edge_select ? (nmi_s && !nmi_prev_q) : (!nmi_s && nmi_prev_q);

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            nmi_prev_q <= 1'b0;
            arm_q <= 2'h0;
        end else begin
            nmi_prev_q <= nmi_s;
            arm_q <= nmi_armed ? arm_q : arm_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    wire all_addr = cfg_q.expanded && !cfg_q.ddr_gated; // modes one to four
    wire [omsc_pkg::P1_W-1:0] p1_d = all_addr ? '1
        : (cfg_q.ddr_gated ? PORT1_DIRECTION : '0);
    wire [omsc_pkg::P2_W-1:0] p2_d = all_addr ? '1
        : (cfg_q.ddr_gated ? PORT2_DIRECTION : '0);
    wire [omsc_pkg::P5_W-1:0] p5_d = all_addr ? '1
        : (cfg_q.ddr_gated ? PORT5_DIRECTION : '0);
    wire wide16 = cfg_q.space16m && cfg_q.expanded;
    wire [omsc_pkg::UPPER_W-1:0] upper_d = wide16 ? ~BUS_RELEASE_CONTROL : '0;
    wire bus16_d = cfg_q.expanded && (|AREA_WIDTH_CONTROL);
    wire route_d = cfg_q.expanded && !sc_q.onchip_ram_enable && RAM_ADDR_HIT;

    // mode outputs; all zero but MODE_RESERVED while the straps read reserved
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            MODE_RESERVED <= 1'b1;
            EXPANDED <= 1'b0;
            ROM_ENABLE <= 1'b0;
            SPACE_16M <= 1'b0;
            BUS_INIT16 <= 1'b0;
            BUS16 <= 1'b0;
        end else begin
            MODE_RESERVED <= !cfg_q.valid;
            EXPANDED <= cfg_q.expanded;
            ROM_ENABLE <= cfg_q.rom_en;
            SPACE_16M <= cfg_q.space16m;
            BUS_INIT16 <= cfg_q.bus_init16;
            BUS16 <= bus16_d;
        end
    end

    // pin roles; mode 7 leaves every port general
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            P1_ADDR_OUT <= '0;
            P2_ADDR_OUT <= '0;
            P5_ADDR_OUT <= '0;
            A20_ADDR_OUT <= 1'b0;
            UPPER_ADDR_OUT <= '0;
            RAM_ROUTE_EXT <= 1'b0;
        end else begin
            P1_ADDR_OUT <= p1_d;
            P2_ADDR_OUT <= p2_d;
            P5_ADDR_OUT <= p5_d;
            A20_ADDR_OUT <= wide16;
            UPPER_ADDR_OUT <= upper_d;
            RAM_ROUTE_EXT <= route_d;
        end
    end

    // control outputs and one-cycle pulses
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            RAM_ENABLE <= 1'b1;
            UI_IS_MASK <= 1'b0;
            SET_I_FLAG <= 1'b0;
            SET_UI_FLAG <= 1'b0;
            NMI_REQUEST <= 1'b0;
        end else begin
            RAM_ENABLE <= sc_q.onchip_ram_enable;
            UI_IS_MASK <= !sc_q.ue;
            SET_I_FLAG <= EXC_ENTRY;
            SET_UI_FLAG <= EXC_ENTRY && !sc_q.ue;
            NMI_REQUEST <= nmi_armed && nmi_edge;
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = slverr_q;
    assign PRDATA = {24'h000000, rdata_q};
    assign SLEEP_ACTIVE = pwr_q[1];
    assign STANDBY_ACTIVE = pwr_q[2];
    assign SETTLING = pwr_q[3];

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    sequence s_held(logic [2:0] m);
        (mode_levels == m) [*2];
    endsequence

    property p_rom_off;
        s_held(omsc_pkg::MODE_3) or s_held(omsc_pkg::MODE_1) |=> !ROM_ENABLE && EXPANDED;
    endproperty
    a_rom_off: assert property (p_rom_off) else $error("rom on in mode 1 or 3");

    property p_rom_on;
        s_held(omsc_pkg::MODE_6) |=> ROM_ENABLE && EXPANDED && SPACE_16M;
    endproperty
    a_rom_on: assert property (p_rom_on) else $error("mode 6 config wrong");

    property p_single;
        s_held(omsc_pkg::MODE_7) |=> !EXPANDED && P1_ADDR_OUT == '0 && !A20_ADDR_OUT;
    endproperty
    a_single: assert property (p_single) else $error("mode 7 drives address");

    property p_init16;
        s_held(omsc_pkg::MODE_4) |=> BUS_INIT16 ##0 !MODE_RESERVED;
    endproperty
    a_init16: assert property (p_init16) else $error("mode 4 not 16-bit");

    property p_bus16;
        cfg_q.expanded |=> BUS16 == (|$past(AREA_WIDTH_CONTROL));
    endproperty
    a_bus16: assert property (p_bus16) else $error("bus width wrong");

    property p_upper;
        cfg_q.space16m && cfg_q.expanded |=> A20_ADDR_OUT && UPPER_ADDR_OUT == ~$past(BUS_RELEASE_CONTROL);
    endproperty
    a_upper: assert property (p_upper) else $error("upper address pins wrong");

    property p_ddr;
        cfg_q.ddr_gated |=> P2_ADDR_OUT == $past(PORT2_DIRECTION);
    endproperty
    a_ddr: assert property (p_ddr) else $error("port 2 not gated");

    property p_route;
        cfg_q.expanded && !sc_q.onchip_ram_enable && RAM_ADDR_HIT |=> RAM_ROUTE_EXT;
    endproperty
    a_route: assert property (p_route) else $error("ram access not routed");

    property p_rb_fixed;
        PREADY && !PSLVERR && !PWRITE && hit_rb |-> PRDATA[7:3] == 5'h18;
    endproperty
    a_rb_fixed: assert property (p_rb_fixed) else $error("readback fixed bits");

    property p_rb_latch;
        PREADY && !PSLVERR && !PWRITE && hit_rb |-> PRDATA[2:0] == $past(mode_levels);
    endproperty
    a_rb_latch: assert property (p_rb_latch) else $error("readback mode bits not latched");

    sequence s_standby_exit;
        STANDBY_ACTIVE && EXT_IRQ;
    endsequence

    property p_software_standby_select_kept;
        s_standby_exit |=> SETTLING && sc_q.software_standby_select;
    endproperty
    a_software_standby_select_kept: assert property (p_software_standby_select_kept) else $error("standby exit wrong");

    property p_short_wait;
        s_standby_exit and sts_short |=> SETTLING [*8];
    endproperty
    a_short_wait: assert property (p_short_wait) else $error("settling too short");

    property p_ui;
        EXC_ENTRY && !sc_q.ue |=> SET_UI_FLAG && SET_I_FLAG ##1 !SET_I_FLAG;
    endproperty
    a_ui: assert property (p_ui) else $error("exception flags wrong");

    property p_nmi_fall;
        nmi_armed && !sc_q.nonmaskable_edge_select && $fell(nmi_s) |=> NMI_REQUEST;
    endproperty
    a_nmi_fall: assert property (p_nmi_fall) else $error("nmi fall missed");

endmodule

`default_nettype wire

// >>> omsc_ctrl_tb.sv
// self-checking bench for the mode decode and system control block
// assumes the apb slave answers with pready and a 16-state base wait
`timescale 1ns/1ns
`default_nettype none
module omsc_ctrl_tb;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic CLK=0, RSTN=0, PSEL=0, PENABLE=0, PWRITE=0, SLP=0, EXT=0, HIT=0, B16, A20, ONCHIP_RAM_ENABLE, UIM, SBY, SET, PRDY, ERR;
    logic EXP, ROM, S16, I16, MRS, RTE, SLA, SI, SU, NRQ, NMI=1, EXC=0, WAK=0;
    logic [17:0] PADDR=0;
    logic [31:0] PWDATA=0, PRDATA, r=32'h7368;
    logic [7:0] AREA=0, P1=0, P2=0, P1O, P2O;
    logic [3:0] P5=0, P5O;
    logic [2:0] REL=0, UPO, strap=3'h1, pins;
    logic [17:0] exp_q[$];
    int miscompares=0, comparisons=0, n;
    bit ex, ddr, s16;
    always #2 CLK = ~CLK;
    omsc_board i_omsc_board (.clk(CLK), .rstn(RSTN), .strap(strap), .levels(pins));
    omsc_ctrl #(.WAIT_BASE(16)) i_omsc_ctrl (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PREADY(PRDY), .PRDATA(PRDATA),
        .PSLVERR(ERR), .MODE_PIN_LEVELS(pins), .NMI_PIN(NMI), .AREA_WIDTH_CONTROL(AREA),
        .BUS_RELEASE_CONTROL(REL), .PORT1_DIRECTION(P1), .PORT2_DIRECTION(P2), .PORT5_DIRECTION(P5),
        .SLEEP_EXEC(SLP), .WAKE_IRQ(WAK), .EXT_IRQ(EXT), .EXC_ENTRY(EXC), .RAM_ADDR_HIT(HIT),
        .MODE_RESERVED(MRS), .EXPANDED(EXP), .ROM_ENABLE(ROM), .SPACE_16M(S16), .BUS_INIT16(I16), .BUS16(B16),
        .P1_ADDR_OUT(P1O), .P2_ADDR_OUT(P2O), .P5_ADDR_OUT(P5O), .A20_ADDR_OUT(A20), .UPPER_ADDR_OUT(UPO),
        .RAM_ENABLE(ONCHIP_RAM_ENABLE), .RAM_ROUTE_EXT(RTE), .SLEEP_ACTIVE(SLA), .STANDBY_ACTIVE(SBY), .SETTLING(SET),
        .UI_IS_MASK(UIM), .SET_I_FLAG(SI), .SET_UI_FLAG(SU), .NMI_REQUEST(NRQ));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic chk(input logic [17:0] g, input logic [17:0] e);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one apb transfer; a read notes its expected error flag and byte
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [8:0] e);
        if (!w) exp_q.push_back({9'h0, e});
        PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= {24'h0, d};
        @(posedge CLK) PENABLE <= 1'b1;
        do @(posedge CLK); while (PRDY !== 1'b1);
        PSEL <= 1'b0; PENABLE <= 1'b0;
        @(posedge CLK);
    endtask
    // read results are matched against the oldest note
    always @(posedge CLK) begin
        if (PSEL && PENABLE && PRDY === 1'b1 && !PWRITE) begin
            chk({8'h00, |PRDATA[31:8], ERR, PRDATA[7:0]}, exp_q.pop_front());
        end
    end
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog well beyond the longest settling wait
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        conclude;
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        for (int m = 7; m > 0; m--) begin
            RSTN <= 1'b0; strap <= m[2:0];
            repeat (20) @(posedge CLK);
            RSTN <= 1'b1; r = xs(r);
            AREA <= r[7:0]; REL <= {3{r[8]}}; P1 <= r[16:9]; P2 <= r[24:17]; P5 <= r[28:25]; HIT <= r[29];
            repeat (6) @(posedge CLK);
            ex = m != 7; ddr = m == 5 || m == 6; s16 = m == 3 || m == 4 || m == 6;
            chk({MRS, EXP, ROM, S16}, {1'b0, ex, m > 4, s16});
            chk({I16, A20, B16}, {m == 2 || m == 4, s16, ex && |AREA});
            chk({P1O, UPO}, {ex ? (ddr ? P1 : 8'hFF) : 8'h00, s16 ? ~REL : 3'h0});
            chk({P2O, P5O}, ex ? (ddr ? {P2, P5} : 12'hFFF) : 12'h000);
            apb(0, omsc_pkg::ADDR_MODE_READBACK, 0, {1'b0, 8'hC0 | m[7:0]});
            apb(1, omsc_pkg::ADDR_MODE_READBACK, 8'hFF, 0);
            apb(0, omsc_pkg::ADDR_MODE_READBACK, 0, {1'b0, 8'hC0 | m[7:0]});
        end
        $display("mode tests done");
        apb(0, omsc_pkg::ADDR_SYSTEM_CONTROL, 0, 9'h00B);
        apb(1, omsc_pkg::ADDR_SYSTEM_CONTROL, 8'h00, 0);
        apb(0, omsc_pkg::ADDR_SYSTEM_CONTROL, 0, 9'h002);
        apb(0, 18'h00000, 0, 9'h100);
        HIT <= 1'b1;
        repeat (2) @(posedge CLK);
        chk({ONCHIP_RAM_ENABLE, UIM, RTE}, 3'b011);
        EXC <= 1'b1; NMI <= 1'b0;
        @(posedge CLK) EXC <= 1'b0;
        @(posedge CLK) chk({SI, SU}, 2'b11);
        repeat (2) @(posedge CLK);
        chk(NRQ, 1);
        NMI <= 1'b1;
        repeat (4) @(posedge CLK);
        chk(NRQ, 0);
        $display("register tests done");
        for (int s = 0; s < 7; s++) begin
            apb(1, omsc_pkg::ADDR_SYSTEM_CONTROL, 8'h89 | (s[7:0] << 4), 0); // short base wait in sim
            SLP <= 1'b1;
            @(posedge CLK) SLP <= 1'b0;
            repeat (3) @(posedge CLK);
            chk(SBY, 1);
            EXT <= 1'b1;
            @(posedge CLK) EXT <= 1'b0;
            do @(posedge CLK); while (SET !== 1'b1);
            for (n = 0; SET === 1'b1; n++) @(posedge CLK);
            chk(n, s == 5 ? 1024 : (s == 6 ? 16 : 16 << s));
        end
        apb(0, omsc_pkg::ADDR_SYSTEM_CONTROL, 0, 9'h0EB);
        apb(1, omsc_pkg::ADDR_SYSTEM_CONTROL, 8'h09, 0);
        SLP <= 1'b1;
        @(posedge CLK) SLP <= 1'b0;
        repeat (2) @(posedge CLK);
        chk({SLA, SBY}, 2'b10);
        WAK <= 1'b1;
        @(posedge CLK) WAK <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(SLA, 0);
        $display("standby tests done");
        conclude;
    end
endmodule
`default_nettype wire

// >>> omsc_pkg.sv
// package for the operating mode and system control block
// assumes one clock domain and an apb slave with 32-bit data

package omsc_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 18;                         // byte address width
    localparam int DATA_W = 32;                         // apb data width
    localparam logic [15:0] IDX_MODE_READBACK = 16'hFFF1;  // register index
    localparam logic [15:0] IDX_SYSTEM_CONTROL = 16'hFFF2; // register index
    localparam logic [ADDR_W-1:0] ADDR_MODE_READBACK = {IDX_MODE_READBACK, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_SYSTEM_CONTROL = {IDX_SYSTEM_CONTROL, 2'b00};

    // ------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SYSCTL_RESET = 8'h0B;   // software_standby_select 0, sts 0, ue 1, edge 0, onchip_ram_enable 1
    localparam logic [7:0] SYSCTL_ONES = 8'h02;    // reserved bit reads one
    localparam logic [7:0] RB_ONES = 8'hC0;        // readback top bits read one
    localparam int SOFTWARE_STANDBY_SELECT_BIT = 7;
    localparam int STS_HI = 6;
    localparam int STS_LO = 4;
    localparam int UE_BIT = 3;
    localparam int NONMASKABLE_EDGE_SELECT_BIT = 2;
    localparam int ONCHIP_RAM_ENABLE_BIT = 0;

    // ------------------------------------------------------------
    // settling wait after standby exit
    // ------------------------------------------------------------
    localparam int CNT_W = 18;                     // holds 131072
    localparam int WAIT_BASE_STATES = 8192;        // code 000
    localparam logic [CNT_W-1:0] WAIT_SHORT_STATES = 18'h00400; // code 101
    localparam logic [2:0] STS_LONGEST = 3'h4;     // last doubling code
    localparam logic [2:0] STS_SHORT = 3'h5;       // short wait code
    localparam logic [1:0] NMI_ARM_CYCLES = 2'h3;  // ignore edges while sync fills

    // ------------------------------------------------------------
    // modes and pin groups
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_RSVD = 3'h0;
    localparam logic [2:0] MODE_1 = 3'h1;
    localparam logic [2:0] MODE_2 = 3'h2;
    localparam logic [2:0] MODE_3 = 3'h3;
    localparam logic [2:0] MODE_4 = 3'h4;
    localparam logic [2:0] MODE_5 = 3'h5;
    localparam logic [2:0] MODE_6 = 3'h6;
    localparam logic [2:0] MODE_7 = 3'h7;
    localparam int P1_W = 8;
    localparam int P2_W = 8;
    localparam int P5_W = 4;
    localparam int AREA_N = 8;
    localparam int UPPER_W = 3;                    // address bits 23 to 21

    // what a mode implies for the rest of the chip
    typedef struct packed {
        logic valid;      // a defined mode
        logic expanded;   // external bus in use
        logic rom_en;     // on-chip rom reachable
        logic space16m;   // 16-mbyte space
        logic bus_init16; // 16-bit bus after reset
        logic ddr_gated;  // address pins follow direction bits
    } omsc_mode_cfg_t;

    // writable system control fields
    typedef struct packed {
        logic software_standby_select;
        logic [2:0] sts;
        logic ue;
        logic nonmaskable_edge_select;
        logic onchip_ram_enable;
    } omsc_sysctl_t;

    typedef enum logic [3:0] {
        PWR_RUN = 4'h1,
        PWR_SLEEP = 4'h2,
        PWR_STANDBY = 4'h4,
        PWR_SETTLE = 4'h8
    } omsc_pwr_t;

    // mode table; code 000 stays all zero
    function automatic omsc_mode_cfg_t omsc_decode(input logic [2:0] m);
        omsc_mode_cfg_t c;
        c = '0;
        c.valid = (m != MODE_RSVD);
        c.expanded = c.valid && (m != MODE_7);
        c.rom_en = (m == MODE_5) || (m == MODE_6) || (m == MODE_7);
        c.space16m = (m == MODE_3) || (m == MODE_4) || (m == MODE_6);
        c.bus_init16 = (m == MODE_2) || (m == MODE_4);
        c.ddr_gated = (m == MODE_5) || (m == MODE_6);
        return c;
    endfunction

endpackage

// >>> omsc_sync.sv
// two-flop synchroniser for pin levels
// assumes the pins are slow levels, not pulses shorter than a clock

`timescale 1ns/1ns
`default_nettype none

module omsc_sync #(
    parameter int W = 1 // number of levels
) (
    input wire logic clk, // system clock
    input wire logic rstn, // sync reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);

    // ------------------------------------------------------------
    // two stages
    // ------------------------------------------------------------
    logic [W-1:0] meta_q; // first stage, read only by q

    // the first stage feeds nothing but the second
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

`default_nettype wire
